// File: sim/acq_seq_chk.sv
// Port-level checker for the acquisition sequencer
`timescale 1ns/10ps
module acq_seq_chk
(
  input wire logic        ref_clk,                        // System clock
  input wire logic        rst_n,                          // Async reset, active low
  input wire logic [31:0] haddr,                          // Bus address
  input wire logic [1:0]  htrans,                         // Bus transfer type
  input wire logic        hwrite,                         // Bus write
  input wire logic [31:0] hwdata,                         // Bus write data
  input wire logic        hsel,                           // Bus select
  input wire logic        hready,                         // Bus ready
  input wire logic        sync_in,                        // Sync line input
  input wire logic        sync_oe_n,                      // Sync line enable
  input wire logic        shared_digital_input_line_out,  // Run trigger
  input wire logic        shared_digital_input_line_oe_n, // Start line enable
  input wire logic        adc_clk,                        // Converter clock
  input wire logic        fifo_we,                        // Buffer write strobe
  input wire logic        fifo_flush                      // Buffer flush pulse
);
  logic        dph_q;
  logic [7:0]  adr_q;
  logic [15:0] ctrl_q;
  wire         run      = shared_digital_input_line_out;
  wire         wr_now   = dph_q && hready;
  wire         start_wr = wr_now && adr_q == 8'h04 && hwdata[0] && !hwdata[1];
  wire         stop_wr  = wr_now && adr_q == 8'h04 && hwdata[1];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Shadow of the control word; refused while running, as the design does
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dph_q  <= 1'b0;
      adr_q  <= 8'h00;
      ctrl_q <= 16'h0000;
    end
    else
    begin
      if (wr_now && adr_q == 8'h00 && !run)
        ctrl_q <= hwdata[15:0];
      if (hready)
      begin
        dph_q <= hsel && htrans[1] && hwrite;
        adr_q <= haddr[7:0];
      end
    end
  end

  sequence s_soft_start;
    start_wr && !run && ctrl_q[4:2] < 3'd2;
  endsequence
  sequence s_flush_pulse;
    fifo_flush ##1 !fifo_flush;
  endsequence

  a_soft_start: assert property (s_soft_start |-> ##[1:2] run)
    else $error("software start did not raise run");
  a_start_cause: assert property ($rose(run) && ctrl_q[4:2] < 3'd2 |->
    $past(start_wr) || $past(start_wr, 2)) else $error("run rose without start");
  a_soft_stop: assert property (stop_wr |-> ##[1:2] !run)
    else $error("software stop did not clear run");
  a_stop_flush: assert property ($fell(run) |-> ##[0:1] s_flush_pulse)
    else $error("no flush pulse after stop");
  a_flush_cause: assert property (fifo_flush |-> !run && ($past(run) || $past(run, 2)))
    else $error("flush without a stop");
  a_base_hold: assert property ($fell(run) && !ctrl_q[5] |->
    $past(stop_wr) || $past(stop_wr, 2)) else $error("base run cleared without stop");
  a_start_dir: assert property (shared_digital_input_line_oe_n == (ctrl_q[4:2] != 3'd1))
    else $error("start line direction wrong");
  a_sync_dir: assert property (sync_oe_n == (ctrl_q[1:0] != 2'd1))
    else $error("sync line direction wrong");
  a_slave_route: assert property (ctrl_q[1:0] == 2'd2 |-> adc_clk == sync_in)
    else $error("slave clock not routed");
  a_we_spacing: assert property (fifo_we |=> !fifo_we [*4])
    else $error("writes closer than a conversion period");
  a_we_in_run: assert property (fifo_we |-> run || $past(run) || $past(run, 2))
    else $error("buffer write while stopped");
endmodule : acq_seq_chk

bind adc_acquisition_sequencer acq_seq_chk u_acq_seq_chk
(
  .ref_clk(ref_clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hsel(hsel), .hready(hready), .sync_in(sync_in), .sync_oe_n(sync_oe_n),
  .shared_digital_input_line_out(shared_digital_input_line_out),
  .shared_digital_input_line_oe_n(shared_digital_input_line_oe_n),
  .adc_clk(adc_clk), .fifo_we(fifo_we), .fifo_flush(fifo_flush)
);

// File: sim/adc_acquisition_sequencer_tb.sv
// Self-checking bench for the acquisition sequencer
`timescale 1ns/10ps
`include "acq_seq_map.svh"
module adc_acquisition_sequencer_tb;
  logic        ref_clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [1:0]  htrans = 2'b00, adc_chan, fifo_wchan;
  logic [13:0] adc_data = 14'h0000, fifo_wdata;
  logic        clk_en = 1'b0, start_en = 1'b0, start_lvl = 1'b0, adc_clk_d = 1'b0;
  logic        hreadyout, hresp, sync_out, sync_oe_n, line_out, line_oe_n, adc_clk;
  logic        fifo_we, fifo_flush, sync_pin, start_pin;
  logic [7:0]  chan_cfg;
  logic [1:0]  chq[$];
  int          gapq[$];
  int          error_cnt = 0, num_checks = 0, gap = 0, flush_cnt = 0;

  adc_acquisition_sequencer u_adc_acquisition_sequencer
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sync_in(sync_pin), .sync_out(sync_out),
    .sync_oe_n(sync_oe_n), .shared_digital_input_line_in(start_pin),
    .shared_digital_input_line_out(line_out), .shared_digital_input_line_oe_n(line_oe_n),
    .adc_clk(adc_clk), .adc_chan(adc_chan), .adc_data(adc_data), .fifo_wdata(fifo_wdata),
    .fifo_wchan(fifo_wchan), .fifo_we(fifo_we), .fifo_flush(fifo_flush), .chan_cfg(chan_cfg)
  );
  ext_sync_src u_ext_sync_src
  (
    .ref_clk(ref_clk), .clk_en(clk_en), .start_en(start_en), .start_lvl(start_lvl),
    .sync_oe_n(sync_oe_n), .sync_out(sync_out), .start_oe_n(line_oe_n),
    .start_out(line_out), .sync_pin(sync_pin), .start_pin(start_pin)
  );

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) adc_data <= adc_data + 14'h0001;
  // Conversion periods between buffer writes
  always @(posedge ref_clk)
  begin
    adc_clk_d <= adc_clk;
    if (adc_clk && !adc_clk_d)
      gap = gap + 1;
    if (fifo_flush === 1'b1)
      flush_cnt++;
    if (fifo_we === 1'b1)
    begin
      chq.push_back(fifo_wchan);
      gapq.push_back(gap);
      gap = 0;
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Master holds each phase until hready is sampled high
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsel   <= 1'b1;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
    // Let the register take the value before anyone looks at it
    @(posedge ref_clk);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string n);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(n, r, e);
  endtask : rdc
  task automatic setup(input logic [31:0] ctrl, input int frame, input int dly,
                       input logic [31:0] lst);
    wr(`ACQ_REG_LIST_ADDR, 32'h0);
    for (int i = 0; i < frame; i++)
      wr(`ACQ_REG_LIST_DATA, 32'(lst[2*i+:2]));
    wr(`ACQ_REG_FRAME, 32'(frame));
    wr(`ACQ_REG_DELAY, 32'(dly));
    wr(`ACQ_REG_CTRL, ctrl);
    chq.delete();
    gapq.delete();
  endtask : setup
  task automatic wait_we(input int n);
    for (int i = 0; i < 3000 && chq.size() < n; i++)
      @(posedge ref_clk);
    chk("write count", 32'(chq.size()), 32'(n));
  endtask : wait_we
  task automatic check_seq(input int n, input int frame, input int dly, input logic [31:0] lst);
    for (int i = 0; i < n; i++)
    begin
      chk("channel", 32'(chq[i]), 32'(lst[2*(i%frame)+:2]));
      if (i > 0)
        chk("gap", 32'(gapq[i]), 32'((i % frame == 0) ? 1 + dly : 1));
    end
  endtask : check_seq
  task automatic stop();
    int n;
    flush_cnt = 0;
    wr(`ACQ_REG_CMD, 32'h2);
    repeat (4) @(posedge ref_clk);
    n = chq.size();
    chk("run off", 32'(line_out), 32'h0);
    chk("flush", 32'(flush_cnt), 32'h1);
    repeat (40) @(posedge ref_clk);
    chk("idle writes", 32'(chq.size()), 32'(n));
  endtask : stop
  task end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #200_000;
    error_cnt++;
    end_sim();
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(`ACQ_REG_CTRL, `ACQ_CTRL_RESET, "ctrl");
    chk("sync_oe_n", 32'(sync_oe_n), 32'h1);
    chk("start_oe_n", 32'(line_oe_n), 32'h1);
    rdc(32'h0000_003C, 32'h0, "unmapped");
    wr(`ACQ_REG_CHAN_CFG, 32'h0000_005A);
    chk("chan_cfg", 32'(chan_cfg), 32'h5A);
    // Internal master clock, master start, list 2 0 3, delay of two
    setup(32'h0000_1805, 3, 2, 32'h0000_0032);
    chk("sync_oe_n", 32'(sync_oe_n), 32'h0);
    chk("start_oe_n", 32'(line_oe_n), 32'h0);
    wr(`ACQ_REG_CMD, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("run", 32'(line_out), 32'h1);
    wait_we(7);
    check_seq(7, 3, 2, 32'h0000_0032);
    wr(`ACQ_REG_CTRL, 32'h0);
    rdc(`ACQ_REG_CTRL, 32'h0000_1805, "ctrl frozen");
    stop();
    // External slave clock, start on rising line edge, one entry
    clk_en   <= 1'b1;
    start_en <= 1'b1;
    setup(32'h0000_180A, 1, 0, 32'h1);
    wr(`ACQ_REG_CMD, 32'h1);
    repeat (20) @(posedge ref_clk);
    chk("armed", 32'(line_out), 32'h0);
    start_lvl <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("run", 32'(line_out), 32'h1);
    start_lvl <= 1'b0;
    wait_we(4);
    chk("run held", 32'(line_out), 32'h1);
    check_seq(4, 1, 0, 32'h1);
    stop();
    // Start line stays driven low: a release would look like a rising edge
    clk_en   <= 1'b0;
    // Revision B: skip one frame, stop after two collected frames
    setup(32'h0000_1C21, 2, 0, 32'h4);
    wr(`ACQ_REG_SKIP, 32'h1);
    wr(`ACQ_REG_COUNT, 32'h2);
    wr(`ACQ_REG_CMD, 32'h1);
    // First frame blocked, the second one written
    repeat (30) @(posedge ref_clk);
    chk("skipped frame", 32'(chq.size()), 32'h0);
    repeat (18) @(posedge ref_clk);
    chk("next frame", 32'(chq.size() > 0), 32'h1);
    wait_we(4);
    repeat (60) @(posedge ref_clk);
    chk("count stop", 32'(line_out), 32'h0);
    chk("writes", 32'(chq.size()), 32'h4);
    check_seq(4, 2, 0, 32'h4);
    end_sim();
  end
endmodule : adc_acquisition_sequencer_tb

// File: sim/ext_sync_src.sv
// External sync clock source and start line driver facing the sequencer
`timescale 1ns/10ps
module ext_sync_src
#(
  parameter int HALF_NS = 50  // 100 ns period, the fastest legal rate
)
(
  input  wire logic ref_clk,    // Bench clock for the released-line pattern
  input  wire logic clk_en,     // Run the external sync clock
  input  wire logic start_en,   // Drive the start line
  input  wire logic start_lvl,  // Level put on the start line
  input  wire logic sync_oe_n,  // Device drives sync when low
  input  wire logic sync_out,   // Device sync level
  input  wire logic start_oe_n, // Device drives start when low
  input  wire logic start_out,  // Device start level
  output logic      sync_pin,   // Resolved sync line
  output logic      start_pin   // Resolved start line
);
  logic clk_q  = 1'b0;
  logic junk_q = 1'b0;
  // Square wave, equal halves, parked when not enabled
  always #(HALF_NS) clk_q = clk_en ? ~clk_q : 1'b0;
  // Sync has no pull-up: a floating line must not look settled
  always @(posedge ref_clk) junk_q <= ~junk_q;
  assign sync_pin  = !sync_oe_n ? sync_out : (clk_en ? clk_q : junk_q);
  assign start_pin = !start_oe_n ? start_out : (start_en ? start_lvl : 1'b1);
endmodule : ext_sync_src

// File: src/acq_seq_map.svh
// Register offsets, field positions, reset values and timing counts for the acquisition sequencer
`ifndef ACQ_SEQ_MAP_SVH
`define ACQ_SEQ_MAP_SVH

`define ACQ_REF_CLK_MHZ      100
`define ACQ_SRC_CLK_MHZ      30
`define ACQ_DIV_MIN          3
`define ACQ_DIV_MAX          30
`define ACQ_SYNC_MIN_NS      100
`define ACQ_SYNC_MAX_NS      1000
`define ACQ_SYNC_MIN_CYC     ((`ACQ_SYNC_MIN_NS * `ACQ_REF_CLK_MHZ + 999) / 1000)
`define ACQ_SYNC_MAX_CYC     ((`ACQ_SYNC_MAX_NS * `ACQ_REF_CLK_MHZ) / 1000)
`define ACQ_SRC_RATIO_NUM    10
`define ACQ_SRC_RATIO_DEN    3
`define ACQ_FRAME_MAX        8192
`define ACQ_FRAME_BASE_MAX   256
`define ACQ_SKIP_MAX         24'hFF_FFFE

`define ACQ_REG_CTRL         12'h000
`define ACQ_REG_CMD          12'h004
`define ACQ_REG_FRAME        12'h008
`define ACQ_REG_DELAY        12'h00C
`define ACQ_REG_SKIP         12'h010
`define ACQ_REG_COUNT        12'h014
`define ACQ_REG_LEVEL        12'h018
`define ACQ_REG_CHAN_CFG     12'h01C
`define ACQ_REG_STATUS       12'h020
`define ACQ_REG_LIST_ADDR    12'h024
`define ACQ_REG_LIST_DATA    12'h028

`define ACQ_CTRL_SYNC_MODE   1:0
`define ACQ_CTRL_START_MODE  4:2
`define ACQ_CTRL_REV_B       5
`define ACQ_CTRL_LEVEL_EN    6
`define ACQ_CTRL_LEVEL_DIR   7
`define ACQ_CTRL_LEVEL_CH    9:8
`define ACQ_CTRL_COUNT_EN    10
`define ACQ_CTRL_DIV         15:11
`define ACQ_CMD_START        0
`define ACQ_CMD_STOP         1

`define ACQ_CTRL_RESET       32'h0000_0000
`define ACQ_DIV_RESET        5'h03

`endif

// File: src/acq_seq_pkg.sv
// Types shared by the acquisition sequencer
package acq_seq_pkg;
  typedef enum logic [1:0] {sync_internal, sync_master, sync_slave} sync_mode_t;
  typedef enum logic [2:0] {start_soft, start_master, start_rise, start_fall} start_mode_t;
  typedef enum logic [1:0] {seq_idle, seq_list, seq_delay} seq_state_t;
endpackage : acq_seq_pkg

// File: src/adc_acquisition_sequencer.sv
// Acquisition sequencer: run trigger, control list, interframe delay, write gating
`timescale 1ns/10ps
`include "acq_seq_map.svh"

// Functional notes
// - Samples taken during interframe delay never reach the buffer write port.
// - Channel range, offset and zero settings are static register outputs.
// - Run trigger sets on software start or external start edge.
// - Base revision clears run only on software stop, then flushes buffer.
// - Master start output mirrors the run trigger exactly.
// - Revision B gates buffer writes by level, skip count and frame count.
// - Level and skip gating never touch run trigger; frame-count stop clears run and the start line output.
// - Frame size from 1 to 256, up to 8192 entries.
// - Delay 0..255 in base revision, 0..65535 in revision B.
// - Control list length always equals frame size.
// - Acquisition always begins with the first list entry.
// - Delay inserted only after the last list entry.
// - Sequencer wraps back to the first entry while running.
// - Each list step and delay step takes one conversion period.
// - Clock sync and start sync are independent settings.
// - Sync line configurable as output of own clock or input.
// - Start line configurable as input or as output.
// - Slave mode routes sync pulses directly to converter clock.
// - Revision B stops after collected-frame count and offers level modes.
// - Internal clock is 30/n MHz, n 3..30, sync line released.
// - Initial-frame skip count accepts 0 to 16777214.
// - Frame-count stop takes effect at end of the last frame.
module adc_acquisition_sequencer
(
  input  wire logic        ref_clk,      // System clock 100 MHz
  input  wire logic        rst_n,        // Async reset, active low
  input  wire logic [31:0] haddr,        // AHB address
  input  wire logic [1:0]  htrans,       // AHB transfer type
  input  wire logic        hwrite,       // AHB write
  input  wire logic [2:0]  hsize,        // AHB size
  input  wire logic [31:0] hwdata,       // AHB write data
  input  wire logic        hsel,         // AHB select
  input  wire logic        hready,       // AHB bus ready
  output logic      [31:0] hrdata,       // AHB read data
  output logic             hreadyout,    // AHB slave ready
  output logic             hresp,        // AHB response
  input  wire logic        sync_in,      // Sync line input
  output logic             sync_out,     // Sync line output
  output logic             sync_oe_n,    // Sync line enable, low drives
  input  wire logic        shared_digital_input_line_in,  // Start line input
  output logic             shared_digital_input_line_out, // Start line output
  output logic             shared_digital_input_line_oe_n,// Start line enable, low drives
  output logic             adc_clk,      // Converter clock
  output logic      [1:0]  adc_chan,     // Channel select to commutator
  input  wire logic [13:0] adc_data,     // Converter sample
  output logic      [13:0] fifo_wdata,   // Buffer write data
  output logic      [1:0]  fifo_wchan,   // Buffer write channel tag
  output logic             fifo_we,      // Buffer write strobe
  output logic             fifo_flush,   // Buffer flush pulse
  output logic      [7:0]  chan_cfg      // Static per-channel front-end settings
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic [31:0] ctrl_q;
  logic [12:0] frame_q;
  logic [15:0] delay_q;
  logic [23:0] skip_q;
  logic [23:0] count_q;
  logic [13:0] level_q;
  logic [7:0]  chan_cfg_q;
  logic [12:0] list_addr_q;
  logic [1:0]  list_mem [0:`ACQ_FRAME_MAX-1];
  logic        run_q;
  logic        wr_ph_q;
  logic [11:0] addr_ph_q;
  logic        soft_start;
  logic        soft_stop;
  logic        cfg_wr;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ph_q   <= 1'b0;
      addr_ph_q <= 12'h000;
    end
    else if (hready)
    begin
      wr_ph_q   <= hsel && htrans[1] && hwrite;
      addr_ph_q <= haddr[11:0];
    end
  end

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  // Start/stop commands are taken at any time; everything else only while stopped
  assign soft_start = wr_ph_q && addr_ph_q == `ACQ_REG_CMD && hwdata[`ACQ_CMD_START];
  assign soft_stop  = wr_ph_q && addr_ph_q == `ACQ_REG_CMD && hwdata[`ACQ_CMD_STOP];
  assign cfg_wr     = wr_ph_q && !run_q;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q      <= `ACQ_CTRL_RESET;
      frame_q     <= 13'h0001;
      delay_q     <= 16'h0000;
      skip_q      <= 24'h00_0000;
      count_q     <= 24'h00_0000;
      level_q     <= 14'h0000;
      chan_cfg_q  <= 8'h00;
      list_addr_q <= 13'h0000;
    end
    else if (cfg_wr)
    begin
      unique case (addr_ph_q)
        `ACQ_REG_CTRL:      ctrl_q     <= hwdata;
        `ACQ_REG_FRAME:
        begin
          if (hwdata[13:0] >= 14'h0001 && hwdata[13:0] <= 14'(`ACQ_FRAME_MAX))
            frame_q <= 13'(hwdata[13:0] - 14'h0001);
        end
        `ACQ_REG_DELAY:     delay_q    <= hwdata[15:0];
        `ACQ_REG_SKIP:
        begin
          if (hwdata[23:0] <= `ACQ_SKIP_MAX)
            skip_q <= hwdata[23:0];
        end
        `ACQ_REG_COUNT:     count_q    <= hwdata[23:0];
        `ACQ_REG_LEVEL:     level_q    <= hwdata[13:0];
        `ACQ_REG_CHAN_CFG:  chan_cfg_q <= hwdata[7:0];
        `ACQ_REG_LIST_ADDR: list_addr_q <= hwdata[12:0];
        `ACQ_REG_LIST_DATA: list_addr_q <= list_addr_q + 13'h0001;
        default:            ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (cfg_wr && addr_ph_q == `ACQ_REG_LIST_DATA)
      list_mem[list_addr_q] <= hwdata[1:0];
  end

  assign chan_cfg = chan_cfg_q;

  // Frame length: revision A limited to the base list size, delay to 8 bits
  logic [12:0] frame_last;
  logic [15:0] delay_eff;
  logic        rev_b;
  assign rev_b      = ctrl_q[`ACQ_CTRL_REV_B];
  assign frame_last = rev_b ? frame_q : {5'h00, frame_q[7:0]};
  assign delay_eff  = rev_b ? delay_q : {8'h00, delay_q[7:0]};

  // ****************************************
  // Input synchronisers and conversion clock
  // ****************************************
  logic [1:0] sync_ff_q;
  logic [1:0] start_ff_q;
  logic       sync_prev_q;
  logic       start_prev_q;
  logic       int_clk_q;
  logic       conv_tick;
  logic       ext_tick;
  logic       int_tick;
  acq_seq_pkg::sync_mode_t  sync_mode;
  acq_seq_pkg::start_mode_t start_mode;
  assign sync_mode  = acq_seq_pkg::sync_mode_t'(ctrl_q[`ACQ_CTRL_SYNC_MODE]);
  assign start_mode = acq_seq_pkg::start_mode_t'(ctrl_q[`ACQ_CTRL_START_MODE]);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_ff_q    <= 2'b00;
      start_ff_q   <= 2'b11;
      sync_prev_q  <= 1'b0;
      start_prev_q <= 1'b1;
    end
    else
    begin
      sync_ff_q    <= {sync_ff_q[0], sync_in};
      start_ff_q   <= {start_ff_q[0], shared_digital_input_line_in};
      sync_prev_q  <= sync_ff_q[1];
      start_prev_q <= start_ff_q[1];
    end
  end

  // Divider approximates 30/n MHz at 100 MHz: toggle every n*10/6 cycles
  logic [5:0] half_q;
  logic [4:0] div_n;
  assign div_n = (ctrl_q[`ACQ_CTRL_DIV] < 5'(`ACQ_DIV_MIN)) ? 5'(`ACQ_DIV_MIN) :
                 (ctrl_q[`ACQ_CTRL_DIV] > 5'(`ACQ_DIV_MAX)) ? 5'(`ACQ_DIV_MAX) :
                 ctrl_q[`ACQ_CTRL_DIV];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_q    <= 6'h00;
      int_clk_q <= 1'b0;
    end
    else if (half_q + 6'h01 >= 6'((div_n * 5 + 2) / 3))
    begin
      half_q    <= 6'h00;
      int_clk_q <= !int_clk_q;
    end
    else
      half_q <= half_q + 6'h01;
  end

  assign int_tick  = (half_q + 6'h01 >= 6'((div_n * 5 + 2) / 3)) && !int_clk_q;
  assign ext_tick  = sync_ff_q[1] && !sync_prev_q;
  assign conv_tick = (sync_mode == acq_seq_pkg::sync_slave) ? ext_tick : int_tick;

  // Slave: raw pin goes straight to the converter, no regeneration
  assign adc_clk   = (sync_mode == acq_seq_pkg::sync_slave) ? sync_in : int_clk_q;
  assign sync_out  = int_clk_q;
  assign sync_oe_n = (sync_mode != acq_seq_pkg::sync_master);

  // ****************************************
  // Run trigger
  // ****************************************
  logic ext_start;
  logic stop_done;
  logic flush_q;
  assign ext_start = (start_mode == acq_seq_pkg::start_rise && start_ff_q[1] && !start_prev_q) ||
                     (start_mode == acq_seq_pkg::start_fall && !start_ff_q[1] && start_prev_q);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q   <= 1'b0;
      flush_q <= 1'b0;
    end
    else
    begin
      flush_q <= run_q && (soft_stop || stop_done);
      if (soft_stop || stop_done)
        run_q <= 1'b0;
      else if (soft_start && start_mode != acq_seq_pkg::start_rise &&
               start_mode != acq_seq_pkg::start_fall)
        run_q <= 1'b1;
      else if (ext_start)
        run_q <= 1'b1;
    end
  end

  assign fifo_flush = flush_q;
  // Start line only looks at run and mode, never at gating
  assign shared_digital_input_line_out  = run_q;
  assign shared_digital_input_line_oe_n = (start_mode != acq_seq_pkg::start_master);

  // ****************************************
  // Control list sequencer
  // ****************************************
  acq_seq_pkg::seq_state_t state_q;
  logic [12:0] idx_q;
  logic [15:0] dly_q;
  logic        frame_end;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= acq_seq_pkg::seq_idle;
      idx_q   <= 13'h0000;
      dly_q   <= 16'h0000;
    end
    else if (!run_q)
    begin
      state_q <= acq_seq_pkg::seq_idle;
      idx_q   <= 13'h0000;
    end
    else if (conv_tick)
    begin
      unique case (state_q)
        acq_seq_pkg::seq_idle:
          state_q <= acq_seq_pkg::seq_list;
        acq_seq_pkg::seq_list:
        begin
          if (idx_q == frame_last)
          begin
            idx_q <= 13'h0000;
            if (delay_eff != 16'h0000)
            begin
              state_q <= acq_seq_pkg::seq_delay;
              dly_q   <= delay_eff - 16'h0001;
            end
          end
          else
            idx_q <= idx_q + 13'h0001;
        end
        acq_seq_pkg::seq_delay:
        begin
          if (dly_q == 16'h0000)
            state_q <= acq_seq_pkg::seq_list;
          else
            dly_q <= dly_q - 16'h0001;
        end
      endcase
    end
  end

  assign frame_end = conv_tick && state_q == acq_seq_pkg::seq_list && idx_q == frame_last;

  // ****************************************
  // Revision B write gating
  // ****************************************
  logic [1:0]  cur_chan_q;
  logic        level_hit_q;
  logic        level_ok_q;
  logic        prev_above_q;
  logic [23:0] skipped_q;
  logic [23:0] collected_q;
  logic        open_q;
  logic        above;
  logic        sample_ok;
  assign above = adc_data > level_q;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cur_chan_q <= 2'b00;
    // Select the entry for the coming period, so each sample carries its own tag
    else if (conv_tick && state_q == acq_seq_pkg::seq_idle)
      cur_chan_q <= list_mem[13'h0000];
    else if (conv_tick && state_q == acq_seq_pkg::seq_list)
      cur_chan_q <= list_mem[(idx_q == frame_last) ? 13'h0000 : idx_q + 13'h0001];
  end

  assign adc_chan = cur_chan_q;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_hit_q  <= 1'b0;
      prev_above_q <= 1'b0;
      level_ok_q   <= 1'b0;
      skipped_q    <= 24'h00_0000;
      collected_q  <= 24'h00_0000;
      open_q       <= 1'b0;
    end
    else if (!run_q)
    begin
      level_hit_q <= 1'b0;
      level_ok_q  <= !ctrl_q[`ACQ_CTRL_LEVEL_EN];
      skipped_q   <= 24'h00_0000;
      collected_q <= 24'h00_0000;
      // No skip and no level condition: the first frame is already open
      open_q      <= !ctrl_q[`ACQ_CTRL_LEVEL_EN] && skip_q == 24'h00_0000;
    end
    else
    begin
      if (conv_tick && state_q == acq_seq_pkg::seq_list &&
          cur_chan_q == ctrl_q[`ACQ_CTRL_LEVEL_CH])
      begin
        prev_above_q <= above;
        if (above != prev_above_q && above == !ctrl_q[`ACQ_CTRL_LEVEL_DIR])
          level_hit_q <= 1'b1;
      end
      if (frame_end)
      begin
        // Decisions take effect only at frame boundaries
        level_ok_q <= level_hit_q || !ctrl_q[`ACQ_CTRL_LEVEL_EN];
        if (skipped_q < skip_q)
          skipped_q <= skipped_q + 24'h00_0001;
        open_q <= (level_hit_q || !ctrl_q[`ACQ_CTRL_LEVEL_EN]) &&
                  (skipped_q + 24'h00_0001 >= skip_q);
        if (open_q)
          collected_q <= collected_q + 24'h00_0001;
      end
    end
  end

  assign stop_done = rev_b && ctrl_q[`ACQ_CTRL_COUNT_EN] && frame_end && open_q &&
                     (collected_q + 24'h00_0001 >= count_q);
  assign sample_ok = !rev_b || (open_q && level_ok_q);

  // ****************************************
  // Buffer write port
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifo_we    <= 1'b0;
      fifo_wdata <= 14'h0000;
      fifo_wchan <= 2'b00;
    end
    else
    begin
      fifo_we <= run_q && conv_tick && state_q == acq_seq_pkg::seq_list && sample_ok;
      if (conv_tick)
      begin
        fifo_wdata <= adc_data;
        fifo_wchan <= cur_chan_q;
      end
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb
  begin
    hrdata = 32'h0000_0000;
    unique case (addr_ph_q)
      `ACQ_REG_CTRL:      hrdata = ctrl_q;
      `ACQ_REG_FRAME:     hrdata = {18'h0_0000, 14'(frame_q) + 14'h0001};
      `ACQ_REG_DELAY:     hrdata = {16'h0000, delay_q};
      `ACQ_REG_SKIP:      hrdata = {8'h00, skip_q};
      `ACQ_REG_COUNT:     hrdata = {8'h00, count_q};
      `ACQ_REG_LEVEL:     hrdata = {18'h0_0000, level_q};
      `ACQ_REG_CHAN_CFG:  hrdata = {24'h00_0000, chan_cfg_q};
      `ACQ_REG_STATUS:    hrdata = {collected_q, 4'h0, open_q, state_q == acq_seq_pkg::seq_delay,
                                    level_hit_q, run_q};
      `ACQ_REG_LIST_ADDR: hrdata = {19'h0_0000, list_addr_q};
      default:            hrdata = 32'h0000_0000;
    endcase
  end

endmodule : adc_acquisition_sequencer
